// ==== sim/spimsc_peer.sv ====
// behavioural external serial slave peripheral, clock phase 0, polarity 0
`timescale 1ns/1ps
module spimsc_peer (
  // serial pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // byte to answer with, byte heard
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh_q;
  initial
  begin
    sh_q    = 8'h00;
    rx_byte = 8'h00;
    miso    = 1'b1;
  end
  // select fall loads the answer so its msb is out before the first edge
  always @(negedge ss_n) sh_q = tx_byte;
  // capture on the leading edge, shift on the trailing one, msb first
  always @(posedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sclk) if (!ss_n) sh_q = {sh_q[6:0], 1'b0};
  // released line flips rather than keep a friendly last value
  always @(sh_q or ss_n) miso = ss_n ? ~miso : sh_q[7];
endmodule : spimsc_peer

// ==== sim/testbench.sv ====
// self-checking bench for the serial port core
`timescale 1ns/1ps
`include "spimsc_defs.svh"
module testbench;
  // clock, reset and register bus
  logic                  clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [`SPIMSC_AW-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  // pins, resolved from the core's enables
  logic                  tb_sclk, tb_mosi, ss_n, p_ss_n, p_miso;
  logic                  sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [7:0]            p_tx, p_rx;
  wire                   sclk_w = sclk_oe ? sclk_o : tb_sclk;
  wire                   mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire                   miso_w = miso_oe ? miso_o : p_miso;
  int                    n_fail, num_checks, cyc, tog, nbad, last, half;
  logic                  prev_s;
  localparam logic [9:0] A_CTRL = {`SPIMSC_IDX_CTRL, 2'h0};
  localparam logic [9:0] A_STAT = {`SPIMSC_IDX_STAT, 2'h0};
  localparam logic [9:0] A_DATA = {`SPIMSC_IDX_DATA, 2'h0};

  spimsc_core DUT (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n));
  spimsc_peer peer (.sclk(sclk_w), .mosi(mosi_w), .ss_n(p_ss_n), .miso(p_miso),
    .tx_byte(p_tx), .rx_byte(p_rx));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // master clock watcher: toggle count and spacing, start delay not judged
  always @(negedge clk)
  begin
    cyc++;
    if (sclk_oe === 1'b1 && sclk_o !== prev_s)
    begin
      if (tog > 0 && cyc - last != half) nbad++;
      tog++;
      last = cyc;
    end
    prev_s = sclk_o;
  end

  task automatic test_done();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t resp got %h exp %h", $time, got, exp);
    end
  endtask : chk_resp
  // every wait is bounded; running out ends the run
  task automatic tick(inout int n);
    n++;
    if (n > 4000)
    begin
      n_fail++;
      $display("MISMATCH t=%0t wait ran out", $time);
      test_done();
    end
  endtask : tick
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  // bus tasks sample readies at the falling edge, release after the rising one
  task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_t, w_t, fin;
    int   n;
    n = 0;
    fin = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!fin)
    begin
      @(negedge clk);
      tick(n);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      fin = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (fin) bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [9:0] a, output logic [7:0] d, output logic [1:0] r);
    logic ar_t, fin;
    int   n;
    n = 0;
    fin = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!fin)
    begin
      @(negedge clk);
      tick(n);
      ar_t = arvalid && arready;
      fin = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (fin) rready <= 1'b0;
    end
  endtask : axi_rd
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_resp(r, `SPIMSC_RESP_OK);
  endtask : wr
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk_byte(d, e);
    chk_resp(r, `SPIMSC_RESP_OK);
  endtask : rd_chk

  // reset values, mapping, unmapped answers refused without effect
  task automatic reg_map();
    logic [7:0] d;
    logic [1:0] r;
    rd_chk(A_CTRL, 8'h00);
    rd_chk(A_STAT, 8'h08);
    axi_rd(10'h04C, d, r);
    chk_resp(r, `SPIMSC_RESP_ERR);
    axi_wr(10'h000, 8'hFF, r);
    chk_resp(r, `SPIMSC_RESP_ERR);
    rd_chk(A_CTRL, 8'h00);
  endtask : reg_map
  // one master byte against the peer; rd chooses whether to drain it
  task automatic m_xfer(input logic [1:0] rate, input logic [7:0] tx, input logic [7:0] prx,
                        input logic [7:0] e_stat, input logic [7:0] e_data, input logic rd);
    int n;
    n = 0;
    p_tx   <= prx;
    p_ss_n <= 1'b0;
    wr(A_STAT, {6'h00, rate});
    wr(A_CTRL, 8'h23);
    tog  = 0;
    nbad = 0;
    half = 1 << (2 * rate);
    wr(A_DATA, tx);
    while (tog < 16)
    begin
      @(posedge clk);
      tick(n);
    end
    cycles(4);
    chk_byte(8'(tog), 8'h10);
    chk_byte(8'(nbad), 8'h00);
    chk_byte(p_rx, tx);
    rd_chk(A_CTRL, 8'h03);
    rd_chk(A_STAT, e_stat);
    if (rd)
    begin
      rd_chk(A_DATA, e_data);
      rd_chk(A_STAT, {6'h02, rate});
    end
    p_ss_n <= 1'b1;
    cycles(2);
  endtask : m_xfer
  // bench plays external master, four bus cycles a level; ph picks the clock phase
  task automatic s_xfer(input logic [7:0] mo, input logic [7:0] e_mi, input logic ph);
    logic [7:0] mi;
    ss_n <= 1'b0;
    cycles(4);
    chk_byte({7'h00, miso_oe}, 8'h01);
    for (int i = 7; i >= 0; i--)
    begin
      if (!ph) tb_mosi <= mo[i];
      cycles(3);
      @(negedge clk);
      if (!ph) mi[i] = miso_w;
      @(posedge clk);
      tb_sclk <= 1'b1;
      if (ph) tb_mosi <= mo[i];
      cycles(3);
      @(negedge clk);
      if (ph) mi[i] = miso_w;
      @(posedge clk);
      tb_sclk <= 1'b0;
    end
    cycles(3);
    ss_n    <= 1'b1;
    tb_mosi <= ~tb_mosi;
    cycles(6);
    chk_byte(mi, e_mi);
  endtask : s_xfer
  // slave: rate bits set yet ignored, resend of the old shifter contents
  task automatic slave_run();
    wr(A_CTRL, 8'h00);
    wr(A_STAT, 8'h03);
    wr(A_CTRL, 8'h01);
    wr(A_DATA, 8'h5A);
    cycles(2);
    rd_chk(A_STAT, 8'h0B);
    s_xfer(8'hC3, 8'h5A, 1'b0);
    rd_chk(A_STAT, 8'h8B);
    rd_chk(A_DATA, 8'hC3);
    s_xfer(8'h96, 8'hC3, 1'b0);
    rd_chk(A_STAT, 8'h8B);
    rd_chk(A_DATA, 8'h96);
    wr(A_CTRL, 8'h00);
    wr(A_CTRL, 8'h05);
    s_xfer(8'h69, 8'h96, 1'b1);
    rd_chk(A_STAT, 8'h8B);
    rd_chk(A_DATA, 8'h69);
  endtask : slave_run

  // main sequence
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, tb_sclk, tb_mosi} = 8'h00;
    {awaddr, araddr, wdata, p_tx} = 60'h0;
    {ss_n, p_ss_n, prev_s} = 3'h6;
    cycles(4);
    rst_n <= 1'b1;
    cycles(2);
    reg_map();
    for (int r = 0; r < 4; r++)
      m_xfer(2'(r), 8'hA5 ^ 8'(r), 8'h3C + 8'(r), 8'h88 | 8'(r), 8'h3C + 8'(r), 1'b1);
    m_xfer(2'h1, 8'h11, 8'h77, 8'h89, 8'h00, 1'b0);
    m_xfer(2'h1, 8'h22, 8'h66, 8'hC9, 8'h77, 1'b1);
    slave_run();
    test_done();
  end
endmodule : testbench

// ==== verilog/spimsc_core.sv ====
// serial port core: AXI4-Lite register slave, flags and pin synchronisers
`timescale 1ns/1ps
`include "spimsc_defs.svh"
module spimsc_core (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // write address channel
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`SPIMSC_AW-1:0]  awaddr,
  input  wire logic [2:0]             awprot,
  // write data channel
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // write response channel
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // read address channel
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [`SPIMSC_AW-1:0]  araddr,
  input  wire logic [2:0]             arprot,
  // read data channel
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // serial clock pin
  input  wire logic                   sclk_i,
  output logic                        sclk_o,
  output logic                        sclk_oe,
  // master-out data pin
  input  wire logic                   mosi_i,
  output logic                        mosi_o,
  output logic                        mosi_oe,
  // master-in data pin
  input  wire logic                   miso_i,
  output logic                        miso_o,
  output logic                        miso_oe,
  // slave select input
  input  wire logic                   ss_n_i
);

  // register select decode, shared by read and write paths
  function automatic spimsc_pkg::spimsc_sel_t dec_sel(input logic [`SPIMSC_AW-1:0] a);
    logic [7:0] idx;
    idx = a[`SPIMSC_AW-1:2];
    if (a[1:0] != 2'h0) dec_sel = spimsc_pkg::sel_none;
    else if (idx == `SPIMSC_IDX_CTRL) dec_sel = spimsc_pkg::sel_ctrl;
    else if (idx == `SPIMSC_IDX_STAT) dec_sel = spimsc_pkg::sel_stat;
    else if (idx == `SPIMSC_IDX_DATA) dec_sel = spimsc_pkg::sel_data;
    else dec_sel = spimsc_pkg::sel_none;
  endfunction : dec_sel

  spimsc_pkg::spimsc_pins_t pin_raw, s1_q, s2_q;
  spimsc_pkg::spimsc_ctrl_t ctrl_q;
  spimsc_pkg::spimsc_sel_t  wsel, rsel;

  logic                  awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]            bresp_q, rresp_q;
  logic [31:0]           rdata_q;
  logic [`SPIMSC_AW-1:0] awaddr_q;
  logic [7:0]            wdata_q;
  logic                  wstrb_q;
  logic                  aw_got_q, w_got_q;
  logic                  aw_fire, w_fire, wr_do, aw_got_d, w_got_d, bvalid_d;
  logic                  ar_fire, rvalid_d;
  logic                  wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
  logic [7:0]            ctrl_v, stat_v, rmux;

  logic [7:0] rx_data_q, tx_buf_q;
  logic       rx_full_q, ovr_q, armed_q, tx_full_q;
  logic       clr, full_eff, rx_acc, ovr_set;
  logic       tx_take, done, busy, sd_o, mosi_oe_w, miso_oe_w;
  logic [7:0] rx_byte;

  // pin synchronisers; select idles high, others low
  assign pin_raw = {sclk_i, mosi_i, miso_i, ss_n_i};
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n) begin
          s1_q[g] <= 1'(g == 0);
          s2_q[g] <= 1'(g == 0);
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate

  // write channel handshakes; address and data may come in either order
  assign aw_fire  = awvalid & awready_q;
  assign w_fire   = wvalid & wready_q;
  assign wr_do    = aw_got_q & w_got_q & ~bvalid_q;
  assign aw_got_d = (aw_got_q | aw_fire) & ~wr_do;
  assign w_got_d  = (w_got_q | w_fire) & ~wr_do;
  assign bvalid_d = wr_do | (bvalid_q & ~bready);
  assign wsel     = dec_sel(awaddr_q);

  // write strobes; only byte lane 0 carries register data
  assign wr_ctrl = wr_do & wstrb_q & (wsel == spimsc_pkg::sel_ctrl);
  assign wr_stat = wr_do & wstrb_q & (wsel == spimsc_pkg::sel_stat);
  assign wr_data = wr_do & wstrb_q & (wsel == spimsc_pkg::sel_data);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
    end else begin
      awready_q <= ~aw_got_d;
      wready_q  <= ~w_got_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      bvalid_q  <= bvalid_d;
    end
  end

  // captured write payload and response code
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      awaddr_q <= '0;
      wdata_q  <= 8'h00;
      wstrb_q  <= 1'b0;
      bresp_q  <= `SPIMSC_RESP_OK;
    end else begin
      if (aw_fire) awaddr_q <= awaddr;
      if (w_fire) wdata_q <= wdata[7:0];
      if (w_fire) wstrb_q <= wstrb[0];
      if (wr_do) bresp_q <= (wsel == spimsc_pkg::sel_none) ? `SPIMSC_RESP_ERR : `SPIMSC_RESP_OK;
    end
  end

  // read channel; the answer comes one cycle after the address is taken
  assign ar_fire  = arvalid & arready_q;
  assign rvalid_d = ar_fire | (rvalid_q & ~rready);
  assign rsel     = dec_sel(araddr);
  assign rd_stat  = ar_fire & (rsel == spimsc_pkg::sel_stat);
  assign rd_data  = ar_fire & (rsel == spimsc_pkg::sel_data);

  // register images; unused bits read zero
  always_comb
  begin
    ctrl_v = 8'h00;
    stat_v = 8'h00;
    ctrl_v[`SPIMSC_CTRL_EN]   = ctrl_q.enable;
    ctrl_v[`SPIMSC_CTRL_MSTR] = ctrl_q.master;
    ctrl_v[`SPIMSC_CTRL_CLOCK_PHASE_BIT] = ctrl_q.clock_phase_bit;
    ctrl_v[`SPIMSC_CTRL_CPOL] = ctrl_q.cpol;
    ctrl_v[`SPIMSC_CTRL_TIE]  = ctrl_q.tie;
    stat_v[`SPIMSC_STAT_RLO]  = ctrl_q.rate[0];
    stat_v[`SPIMSC_STAT_RHI]  = ctrl_q.rate[1];
    stat_v[`SPIMSC_STAT_TXE]  = ~tx_full_q;
    stat_v[`SPIMSC_STAT_OVR]  = ovr_q;
    stat_v[`SPIMSC_STAT_RXF]  = rx_full_q;
  end

  assign rmux = (rsel == spimsc_pkg::sel_ctrl) ? ctrl_v :
                (rsel == spimsc_pkg::sel_stat) ? stat_v :
                (rsel == spimsc_pkg::sel_data) ? rx_data_q : 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `SPIMSC_RESP_OK;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_fire) rdata_q <= {24'h00_0000, rmux};
      if (ar_fire) rresp_q <= (rsel == spimsc_pkg::sel_none) ? `SPIMSC_RESP_ERR : `SPIMSC_RESP_OK;
    end
  end

  // control fields; a data write drops the interrupt enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q.enable <= wdata_q[`SPIMSC_CTRL_EN];
      if (wr_ctrl) ctrl_q.master <= wdata_q[`SPIMSC_CTRL_MSTR];
      if (wr_ctrl) ctrl_q.clock_phase_bit   <= wdata_q[`SPIMSC_CTRL_CLOCK_PHASE_BIT];
      if (wr_ctrl) ctrl_q.cpol   <= wdata_q[`SPIMSC_CTRL_CPOL];
      if (wr_data) ctrl_q.tie    <= 1'b0;
      else if (wr_ctrl) ctrl_q.tie <= wdata_q[`SPIMSC_CTRL_TIE];
      if (wr_stat) ctrl_q.rate   <= {wdata_q[`SPIMSC_STAT_RHI], wdata_q[`SPIMSC_STAT_RLO]};
    end
  end

  // receive flags: a byte finishing on the clearing read still lands
  assign clr      = rd_data & armed_q;
  assign full_eff = rx_full_q & ~clr;
  assign rx_acc   = done & ~full_eff;
  assign ovr_set  = done & full_eff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      armed_q   <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      rx_full_q <= rx_acc | full_eff;
      ovr_q     <= ovr_set | (ovr_q & ~clr);
      armed_q   <= rd_stat ? (rx_full_q | ovr_q) : (armed_q & ~rd_data);
      if (rx_acc) rx_data_q <= rx_byte;
    end
  end

  // transmit buffer; held until the shifter is idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else begin
      tx_full_q <= wr_data | (tx_full_q & ~tx_take);
      if (wr_data) tx_buf_q <= wdata_q;
    end
  end

  spimsc_shift u_shift (
    .clk      (clk),
    .rst_n    (rst_n),
    .ctrl     (ctrl_q),
    .tx_valid (tx_full_q),
    .tx_byte  (tx_buf_q),
    .tx_take  (tx_take),
    .pin_s    (s2_q),
    .done     (done),
    .rx_byte  (rx_byte),
    .busy     (busy),
    .sclk_o   (sclk_o),
    .sclk_oe  (sclk_oe),
    .sd_o     (sd_o),
    .mosi_oe  (mosi_oe_w),
    .miso_oe  (miso_oe_w)
  );

  // bus and pin outputs
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign mosi_o  = sd_o;           // same shift bit feeds both data pins
  assign mosi_oe = mosi_oe_w;
  assign miso_o  = sd_o;
  assign miso_oe = miso_oe_w;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rx_latch_a: assert property (done && !full_eff |=> rx_full_q && rx_data_q == $past(rx_byte))
    else $error("completed byte not latched with full flag");
  ovr_keep_a: assert property (done && full_eff |=> ovr_q && $stable(rx_data_q))
    else $error("overrun did not keep the unread byte");
  rxf_clear_a: assert property (rd_data && armed_q && !done |=> !rx_full_q)
    else $error("full flag not cleared by status then data read");
  rxf_hold_a: assert property (rx_full_q && !clr |=> rx_full_q)
    else $error("full flag dropped without the read sequence");
  tie_clear_a: assert property (wr_data |=> !ctrl_q.tie)
    else $error("data write left interrupt enable set");
  txe_load_a: assert property (wr_data && !busy && ctrl_q.enable |=> ##1 !tx_full_q)
    else $error("idle shifter did not take written byte");
  bad_addr_a: assert property (ar_fire && rsel == spimsc_pkg::sel_none
                               |=> rvalid && rresp == `SPIMSC_RESP_ERR)
    else $error("unmapped read not answered with error");

  master_done_c: cover property (done && ctrl_q.master);
  slave_done_c:  cover property (done && !ctrl_q.master);
  overrun_c:     cover property (ovr_set);
endmodule : spimsc_core

// ==== verilog/spimsc_defs.svh ====
// constants for the master/slave serial port core
`ifndef SPIMSC_DEFS_SVH
`define SPIMSC_DEFS_SVH
// What this block does
// - master bit set: master; clear: slave
// - only master starts, by data write
// - write when shifter idle loads it, empty set
// - rate bits pick one of four clocks
// - master shifts in while shifting out
// - master done sets full, latches received byte
// - full clears: status read, then data read
// - data write clears transmit-empty interrupt enable
// - slave byte done sets full, latches byte
// - slave accepts clock up to bus rate; code samples sclk in two bus-clock flops, each level must last a bus cycle
// - rate bits ignored in slave mode
// - slave shifts out on miso at start
// - late write: old shift contents go out
// - write during transfer waits in buffer
// - slave start: phase set edge, else select fall
// - three registers at consecutive indices
// - master divides bus clock 2, 8, 32, 128
// - overrun keeps old byte, drops new
`define SPIMSC_AW        10
`define SPIMSC_IDX_CTRL  8'h10
`define SPIMSC_IDX_STAT  8'h11
`define SPIMSC_IDX_DATA  8'h12
`define SPIMSC_CTRL_EN   3'h0
`define SPIMSC_CTRL_MSTR 3'h1
`define SPIMSC_CTRL_CLOCK_PHASE_BIT 3'h2
`define SPIMSC_CTRL_CPOL 3'h3
`define SPIMSC_CTRL_TIE  3'h5
`define SPIMSC_STAT_RLO  3'h0
`define SPIMSC_STAT_RHI  3'h1
`define SPIMSC_STAT_TXE  3'h3
`define SPIMSC_STAT_OVR  3'h6
`define SPIMSC_STAT_RXF  3'h7
`define SPIMSC_RESP_OK   2'h0
`define SPIMSC_RESP_ERR  2'h2
`define SPIMSC_LIM_DIV2  6'h00
`define SPIMSC_LIM_DIV8  6'h03
`define SPIMSC_LIM_DIV32 6'h0F
`define SPIMSC_LIM_DV128 6'h3F
`define SPIMSC_LAST_EDGE 4'hF
`endif

// ==== verilog/spimsc_pkg.sv ====
// types shared by the serial port core
package spimsc_pkg;
  typedef struct packed {
    logic       tie;
    logic       cpol;
    logic       clock_phase_bit;
    logic       master;
    logic       enable;
    logic [1:0] rate;
  } spimsc_ctrl_t;
  // pin levels, sclk first, select last
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } spimsc_pins_t;
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_run  = 2'h2
  } spimsc_state_t;
  typedef enum logic [2:0] {
    sel_none = 3'h0,
    sel_ctrl = 3'h1,
    sel_stat = 3'h2,
    sel_data = 3'h4
  } spimsc_sel_t;
endpackage : spimsc_pkg

// ==== verilog/spimsc_shift.sv ====
// shift engine: master clock generation, slave edge tracking, byte shifting
`timescale 1ns/1ps
module spimsc_shift (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // configuration
  input  wire spimsc_pkg::spimsc_ctrl_t ctrl,
  // transmit buffer handoff
  input  wire logic                     tx_valid,
  input  wire logic [7:0]               tx_byte,
  output logic                          tx_take,
  // synchronised pin levels
  input  wire spimsc_pkg::spimsc_pins_t pin_s,
  // received byte and busy status
  output logic                          done,
  output logic [7:0]                    rx_byte,
  output logic                          busy,
  // pin drive
  output logic                          sclk_o,
  output logic                          sclk_oe,
  output logic                          sd_o,
  output logic                          mosi_oe,
  output logic                          miso_oe
);
`include "spimsc_defs.svh"
  spimsc_pkg::spimsc_state_t st_q, st_d;
  logic [5:0] cnt_q;
  logic [5:0] lim;
  logic [3:0] idx_q;
  logic [7:0] sh_q;
  logic       samp_q, sclk_q, sclk_p_q, ss_p_q;
  logic       sclk_oe_q, mosi_oe_q, miso_oe_q;
  logic       run, ms, en, m_tick, s_edge, ss_fall, s_start, m_start;
  logic       edge_ev, din, samp, last, abort;
  logic [1:0] mstb_q;
  logic [2:0] mfin_q;
  logic [7:0] mrx_q;

  function automatic logic [5:0] rate_lim(input logic [1:0] r);
    unique case (r)
      2'h0: rate_lim = `SPIMSC_LIM_DIV2;
      2'h1: rate_lim = `SPIMSC_LIM_DIV8;
      2'h2: rate_lim = `SPIMSC_LIM_DIV32;
      2'h3: rate_lim = `SPIMSC_LIM_DV128;
    endcase
  endfunction : rate_lim

  // start, edge and sampling decode
  assign run     = (st_q == spimsc_pkg::st_run);
  assign ms      = ctrl.master;
  assign en      = ctrl.enable;
  assign lim     = rate_lim(ctrl.rate);
  assign m_tick  = run & ms & (cnt_q == lim);
  assign s_edge  = pin_s.sclk ^ sclk_p_q;
  assign ss_fall = ss_p_q & ~pin_s.ss_n;
  assign s_start = ~run & en & ~ms & ~pin_s.ss_n & (ctrl.clock_phase_bit ? s_edge : ss_fall);
  assign m_start = ~run & en & ms & tx_valid;
  assign tx_take = ~run & en & tx_valid;
  assign edge_ev = ms ? m_tick : (s_edge & ~pin_s.ss_n & (run | (s_start & ctrl.clock_phase_bit)));
  assign din     = ms ? pin_s.miso : pin_s.mosi;
  assign samp    = (idx_q[0] == ctrl.clock_phase_bit);
  assign last    = edge_ev & (idx_q == `SPIMSC_LAST_EDGE);
  assign abort   = run & (~en | (~ms & pin_s.ss_n));
  assign done    = ms ? mfin_q[2] : (last & ~abort);
  assign rx_byte = ms ? mrx_q : {sh_q[6:0], samp ? din : samp_q};
  assign busy    = run;
  assign sclk_o  = sclk_q;
  assign sclk_oe = sclk_oe_q;
  assign sd_o    = sh_q[7];
  assign mosi_oe = mosi_oe_q;
  assign miso_oe = miso_oe_q;

  // idle/run sequencing
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      spimsc_pkg::st_idle: if (m_start | s_start) st_d = spimsc_pkg::st_run;
      spimsc_pkg::st_run:  if (abort | last) st_d = spimsc_pkg::st_idle;
      default:             st_d = spimsc_pkg::st_idle;
    endcase
  end

  // state, divider, edge index
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      st_q  <= spimsc_pkg::st_idle;
      cnt_q <= 6'h00;
      idx_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (~run | m_tick) ? 6'h00 : cnt_q + 6'h01;
      idx_q <= (abort | last | (~run & ~s_start)) ? 4'h0 : (edge_ev ? idx_q + 4'h1 : idx_q);
    end
  end

  // shift register: load, sample, shift
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      sh_q   <= 8'h00;
      samp_q <= 1'b0;
    end else begin
      if (tx_take) sh_q <= tx_byte;
      else if (done & ~ms) sh_q <= rx_byte;
      else if (edge_ev & ~samp & (idx_q != 4'h0)) sh_q <= {sh_q[6:0], samp_q};
      if (edge_ev & samp) samp_q <= din;
    end
  end

  // master input lags two synchroniser flops; delayed strobes take the bit
  // that stood at the clock edge, even at half the bus rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      mstb_q <= 2'h0;
      mfin_q <= 3'h0;
      mrx_q  <= 8'h00;
    end else begin
      mstb_q <= {mstb_q[0], ms & edge_ev & samp};
      mfin_q <= {mfin_q[1:0], ms & last & ~abort};
      if (mstb_q[1]) mrx_q <= {mrx_q[6:0], pin_s.miso};
    end
  end

  // pin drive and edge history; clock parks at polarity when idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      sclk_q    <= 1'b0;
      sclk_p_q  <= 1'b0;
      ss_p_q    <= 1'b1;
      sclk_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      sclk_q    <= m_tick ? ~sclk_q : (run ? sclk_q : ctrl.cpol);
      sclk_p_q  <= pin_s.sclk;
      ss_p_q    <= pin_s.ss_n;
      sclk_oe_q <= en & ms;
      mosi_oe_q <= en & ms;
      miso_oe_q <= en & ~ms & ~pin_s.ss_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  div_two_a: assert property (m_tick && ctrl.rate == 2'h0 && idx_q != 4'hF |=> m_tick)
    else $error("fastest master clock not half the bus rate");
  div_slow_a: assert property (m_tick && ctrl.rate == 2'h3 |=> (!m_tick)[*8])
    else $error("slowest master clock ticks too early");
  slave_norate_a: assert property (!ms |-> !m_tick)
    else $error("rate generator runs in slave mode");
  role_pins_a: assert property (en && ms |=> sclk_oe && !miso_oe)
    else $error("master does not drive serial clock");
  miso_drive_a: assert property (en && !ms && !pin_s.ss_n |=> miso_oe && !sclk_oe)
    else $error("selected slave not driving miso");
  no_reload_a: assert property (run && !edge_ev |=> $stable(sh_q))
    else $error("shift register reloaded during transfer");
endmodule : spimsc_shift
